// ---- core/dcfg_regs.svh ----
`ifndef DCFG_REGS_SVH
`define DCFG_REGS_SVH
// Register indices; the byte address is the index times four
`define DCFG_IDX_POL       8'h12
`define DCFG_IDX_ROUTE     8'h13
`define DCFG_IDX_OFSA_LO   8'h14
`define DCFG_IDX_OFSB_LO   8'h15
`define DCFG_IDX_OFSA_HI   8'h16
`define DCFG_IDX_OFSB_HI   8'h17
`define DCFG_ADDR_POL      12'h048
`define DCFG_ADDR_ROUTE    12'h04c
`define DCFG_ADDR_OFSA_LO  12'h050
`define DCFG_ADDR_OFSB_LO  12'h054
`define DCFG_ADDR_OFSA_HI  12'h058
`define DCFG_ADDR_OFSB_HI  12'h05c
`define DCFG_ADDR_STATUS   12'h060
// Reset values
`define DCFG_RST_POL       8'h02
`define DCFG_RST_ROUTE     8'h00
`define DCFG_RST_OFS       8'h00
// Field positions
`define DCFG_BIT_INV_A     3
`define DCFG_BIT_INV_B     2
`define DCFG_BIT_SYNC_EN   1
`define DCFG_BIT_A_TO_B    7
`define DCFG_BIT_B_TO_A    6
`define DCFG_BIT_SYNC_SEL  1
`define DCFG_BIT_REV       0
`define DCFG_OFS_HI_MSB    7
`define DCFG_OFS_HI_LSB    3
`endif

// ---- core/dcfg_pkg.sv ----
package dcfg_pkg;
    // Source of clock divider alignment
    typedef enum logic [0:0]
    {
        DCFG_SRC_STROBE = 1'b0,
        DCFG_SRC_FRAME  = 1'b1
    } dcfg_src_e;
    // Offset correction word
    typedef logic [12:0] dcfg_ofs_t;
endpackage

// ---- core/dcfg_clkdiv.sv ----
`timescale 1ns/10ps
// Clock divider producing aligned enable pulses, reset by a sync event
module dcfg_clkdiv
#(
    parameter int DIV_W = 2
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             sync_pulse,
    output logic [DIV_W-1:0]      div_en,
    output logic [DIV_W-1:0]      phase
);
    logic [DIV_W-1:0] count_reg;   // Common counter
    logic             run_and;     // All counter bits so far are set
    // All divided rates come from one counter so they stay aligned
    always_ff @(posedge clock)
    begin
        if (rst || sync_pulse)
            count_reg <= '0;
        else
            count_reg <= count_reg + 1'b1;
    end
    // Enable for divide by 2**(i+1)
    always_comb
    begin
        run_and = 1'b1;
        // Running AND keeps every part-select constant
        for (int i = 0; i < DIV_W; i++)
        begin
            run_and   = run_and & count_reg[i];
            div_en[i] = run_and;
        end
    end
    assign phase = count_reg;
endmodule

// ---- core/dcfg_top.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module dcfg_top
#(
    parameter int DATA_W = 16,
    parameter int DIV_W  = 2
)
(
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              external_sync_strobe,
    input  wire logic              frame_marker,
    input  wire logic              in_valid,
    input  wire logic [DATA_W-1:0] in_a,
    input  wire logic [DATA_W-1:0] in_b,
    output logic                   out_valid,
    output logic [DATA_W-1:0]      out_a,
    output logic [DATA_W-1:0]      out_b,
    output logic                   div_sync,
    output logic [DIV_W-1:0]       div_en,
    output logic                   autosync
);
`include "dcfg_regs.svh"

    // Reverse bit order of a word
    function automatic logic [DATA_W-1:0] rev_bits(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_W; i++)
            r[i] = d[DATA_W-1-i];
        return r;
    endfunction

    // Sign extend the joined 13-bit offset to the data width
    function automatic logic [DATA_W-1:0] ofs_ext(input dcfg_pkg::dcfg_ofs_t o);
        return {{(DATA_W-13){o[12]}}, o};
    endfunction

    logic [7:0]         pol_reg;      // Polarity and sync control
    logic [7:0]         route_reg;    // Routing and sync source
    logic [7:0]         ofsa_lo_reg;  // Offset A low shadow
    logic [7:0]         ofsb_lo_reg;  // Offset B low shadow
    logic [7:0]         ofsa_hi_reg;  // Offset A high shadow
    logic [7:0]         ofsb_hi_reg;  // Offset B high shadow
    dcfg_pkg::dcfg_ofs_t act_a_reg;   // Active offset A
    dcfg_pkg::dcfg_ofs_t act_b_reg;   // Active offset B
    logic               src_prev_reg; // Previous sync source level
    logic               load_next;    // Autosync this cycle
    logic               wr_en;        // Write access phase
    logic               src_lvl;      // Selected sync source level
    logic               sync_next;    // Divider sync event
    logic [DIV_W-1:0]   div_en_w;     // Divider enables
    logic [DIV_W-1:0]   div_ph_w;     // Divider phase
    logic [DATA_W-1:0]  a_w;          // Data after reversal
    logic [DATA_W-1:0]  b_w;
    logic [DATA_W-1:0]  a_src;        // Data after routing
    logic [DATA_W-1:0]  b_src;

    // Write is taken in the access phase; slave answers with no wait
    assign wr_en = psel && penable && pwrite;

    // Software register writes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pol_reg     <= `DCFG_RST_POL;
            route_reg   <= `DCFG_RST_ROUTE;
            ofsa_lo_reg <= `DCFG_RST_OFS;
            ofsb_lo_reg <= `DCFG_RST_OFS;
            ofsa_hi_reg <= `DCFG_RST_OFS;
            ofsb_hi_reg <= `DCFG_RST_OFS;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                `DCFG_ADDR_POL:     pol_reg     <= pwdata[7:0];
                `DCFG_ADDR_ROUTE:   route_reg   <= pwdata[7:0];
                `DCFG_ADDR_OFSA_LO: ofsa_lo_reg <= pwdata[7:0];
                `DCFG_ADDR_OFSB_LO: ofsb_lo_reg <= pwdata[7:0];
                `DCFG_ADDR_OFSA_HI: ofsa_hi_reg <= pwdata[7:0];
                `DCFG_ADDR_OFSB_HI: ofsb_hi_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Only a write to offset A low triggers a load
    assign load_next = wr_en && (paddr == `DCFG_ADDR_OFSA_LO);

    // Autosync pulse output, one cycle after the write
    always_ff @(posedge clock)
    begin
        if (rst)
            autosync <= 1'b0;
        else
            autosync <= load_next;
    end

    // Active offsets change together, only on autosync
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            act_a_reg <= '0;
            act_b_reg <= '0;
        end
        else if (load_next)
        begin
            // New offset A low byte comes straight from the bus data
            act_a_reg <= {ofsa_hi_reg[`DCFG_OFS_HI_MSB:`DCFG_OFS_HI_LSB], pwdata[7:0]};
            act_b_reg <= {ofsb_hi_reg[`DCFG_OFS_HI_MSB:`DCFG_OFS_HI_LSB], ofsb_lo_reg};
        end
        // Otherwise hold: shadow writes leave them alone
    end

    // Read data and handshake, answer in the access phase
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable)
            begin
                unique case (paddr)
                    `DCFG_ADDR_POL:     prdata <= {24'h000000, pol_reg};
                    `DCFG_ADDR_ROUTE:   prdata <= {24'h000000, route_reg};
                    `DCFG_ADDR_OFSA_LO: prdata <= {24'h000000, ofsa_lo_reg};
                    `DCFG_ADDR_OFSB_LO: prdata <= {24'h000000, ofsb_lo_reg};
                    `DCFG_ADDR_OFSA_HI: prdata <= {24'h000000, ofsa_hi_reg};
                    `DCFG_ADDR_OFSB_HI: prdata <= {24'h000000, ofsb_hi_reg};
                    `DCFG_ADDR_STATUS:  prdata <= {5'h00, act_b_reg, 1'b0, act_a_reg};
                    default:            pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Pick the sync source level
    assign src_lvl = route_reg[`DCFG_BIT_SYNC_SEL] ? frame_marker : external_sync_strobe;

    // Rising edge of the source, gated by the enable
    assign sync_next = pol_reg[`DCFG_BIT_SYNC_EN] && src_lvl && !src_prev_reg;

    // Edge history, sync pulse and registered divider enables
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            src_prev_reg <= 1'b0;
            div_sync     <= 1'b0;
            div_en       <= '0;
        end
        else
        begin
            src_prev_reg <= src_lvl;
            div_sync     <= sync_next;
            div_en       <= div_en_w;
        end
    end

    // Shared divider restarts from zero on sync
    dcfg_clkdiv #(.DIV_W(DIV_W)) u_div
    (
        .clock      (clock),
        .rst        (rst),
        .sync_pulse (sync_next),
        .div_en     (div_en_w),
        .phase      (div_ph_w)
    );

    // Reverse per channel; complement follows in the output register
    always_comb
    begin
        a_w = route_reg[`DCFG_BIT_REV] ? rev_bits(in_a) : in_a;
        b_w = route_reg[`DCFG_BIT_REV] ? rev_bits(in_b) : in_b;
        // Duplicate one channel onto the other
        a_src = route_reg[`DCFG_BIT_B_TO_A] ? b_w : a_w;
        b_src = route_reg[`DCFG_BIT_A_TO_B] ? a_w : b_w;
    end

    // Output register: complement then offset add
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            out_a     <= '0;
            out_b     <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            out_valid <= in_valid;
            out_a <= (pol_reg[`DCFG_BIT_INV_A] ? ~a_src : a_src) + ofs_ext(act_a_reg);
            out_b <= (pol_reg[`DCFG_BIT_INV_B] ? ~b_src : b_src) + ofs_ext(act_b_reg);
        end
    end

    // Autosync follows a write to offset A low by one cycle
    a_autosync_pulse: assert property (@(posedge clock) disable iff (rst)
        (wr_en && paddr == `DCFG_ADDR_OFSA_LO) |=> autosync)
        else $error("autosync missing after offset write");

    // Active offsets A and B steady without autosync
    a_offset_hold: assert property (@(posedge clock) disable iff (rst)
        !load_next |=> $stable(act_a_reg) && $stable(act_b_reg))
        else $error("offset changed without autosync");

    // Offset B loads from its shadows with autosync
    a_offset_load: assert property (@(posedge clock) disable iff (rst)
        load_next |=> act_b_reg == {$past(ofsb_hi_reg[7:3]), $past(ofsb_lo_reg)})
        else $error("offset B not loaded on autosync");

    // Sync blocked when disabled
    a_sync_gate: assert property (@(posedge clock) disable iff (rst)
        !pol_reg[1] |=> !div_sync)
        else $error("divider sync while disabled");

    // Divider restarts aligned after sync
    a_div_align: assert property (@(posedge clock) disable iff (rst)
        sync_next |=> div_ph_w == '0)
        else $error("divider not aligned after sync");

    // Channel A inversion without offset or routing
    a_invert_a: assert property (@(posedge clock) disable iff (rst)
        (pol_reg[3] && route_reg == 8'h00 && act_a_reg == '0) |=> out_a == ~$past(in_a))
        else $error("channel A not inverted");

    // Channel B inversion without offset or routing
    a_invert_b: assert property (@(posedge clock) disable iff (rst)
        (pol_reg[2] && route_reg == 8'h00 && act_b_reg == '0) |=> out_b == ~$past(in_b))
        else $error("channel B not inverted");

    // A copied onto B
    a_copy_ab: assert property (@(posedge clock) disable iff (rst)
        (route_reg == 8'h80 && pol_reg[3:2] == 2'b00 && act_b_reg == '0) |=> out_b == $past(in_a))
        else $error("A not driven onto B");

    // B copied onto A
    a_copy_ba: assert property (@(posedge clock) disable iff (rst)
        (route_reg == 8'h40 && pol_reg[3:2] == 2'b00 && act_a_reg == '0) |=> out_a == $past(in_b))
        else $error("B not driven onto A");

    // Bit reversal
    a_reverse: assert property (@(posedge clock) disable iff (rst)
        (route_reg == 8'h01 && pol_reg[3:2] == 2'b00 && act_a_reg == '0) |=> out_a == rev_bits($past(in_a)))
        else $error("bit order not reversed");

    // Offset A loads from its high shadow and the written low byte
    a_offset_load_a: assert property (@(posedge clock) disable iff (rst)
        load_next |=> act_a_reg == {$past(ofsa_hi_reg[7:3]), $past(pwdata[7:0])})
        else $error("offset A not loaded on autosync");

    // No autosync pulse without a write to offset A low
    a_autosync_quiet: assert property (@(posedge clock) disable iff (rst)
        !load_next |=> !autosync)
        else $error("autosync without offset write");

    // Every accepted sync event shows as a divider sync pulse
    a_sync_pulse: assert property (@(posedge clock) disable iff (rst)
        sync_next |=> div_sync)
        else $error("divider sync pulse missing");

    // Strobe selected and low: frame edges are ignored
    a_src_strobe: assert property (@(posedge clock) disable iff (rst)
        (!route_reg[`DCFG_BIT_SYNC_SEL] && !external_sync_strobe) |=> !div_sync)
        else $error("sync taken from unselected frame");

    // Frame selected and low: strobe edges are ignored
    a_src_frame: assert property (@(posedge clock) disable iff (rst)
        (route_reg[`DCFG_BIT_SYNC_SEL] && !frame_marker) |=> !div_sync)
        else $error("sync taken from unselected strobe");

    // Slowest enable only coincides with the fastest one
    a_div_nested: assert property (@(posedge clock) disable iff (rst)
        div_en_w[DIV_W-1] |-> div_en_w[0])
        else $error("divided enables out of phase");

    // Divider phase advances by one when no sync arrives
    a_div_count: assert property (@(posedge clock) disable iff (rst)
        !sync_next |=> div_ph_w == $past(div_ph_w) + 1'b1)
        else $error("divider phase skipped");

    // Offset A added with no inversion, routing or reversal
    a_offset_add_a: assert property (@(posedge clock) disable iff (rst)
        (pol_reg[3:2] == 2'b00 && route_reg[7:6] == 2'b00 && !route_reg[0])
        |=> out_a == $past(in_a) + ofs_ext($past(act_a_reg)))
        else $error("offset A not added");

    // Offset B added with no inversion, routing or reversal
    a_offset_add_b: assert property (@(posedge clock) disable iff (rst)
        (pol_reg[3:2] == 2'b00 && route_reg[7:6] == 2'b00 && !route_reg[0])
        |=> out_b == $past(in_b) + ofs_ext($past(act_b_reg)))
        else $error("offset B not added");

    // Offset A low byte written into its shadow
    a_shadow_a_lo: assert property (@(posedge clock) disable iff (rst)
        (wr_en && paddr == `DCFG_ADDR_OFSA_LO) |=> ofsa_lo_reg == $past(pwdata[7:0]))
        else $error("offset A low byte not stored");

    // Offset B low byte written into its shadow
    a_shadow_b_lo: assert property (@(posedge clock) disable iff (rst)
        (wr_en && paddr == `DCFG_ADDR_OFSB_LO) |=> ofsb_lo_reg == $past(pwdata[7:0]))
        else $error("offset B low byte not stored");

    // Offset A high field written into its shadow
    a_shadow_a_hi: assert property (@(posedge clock) disable iff (rst)
        (wr_en && paddr == `DCFG_ADDR_OFSA_HI) |=> ofsa_hi_reg == $past(pwdata[7:0]))
        else $error("offset A high field not stored");

    // Offset B high field written into its shadow
    a_shadow_b_hi: assert property (@(posedge clock) disable iff (rst)
        (wr_en && paddr == `DCFG_ADDR_OFSB_HI) |=> ofsb_hi_reg == $past(pwdata[7:0]))
        else $error("offset B high field not stored");
endmodule

// ---- bench/dcfg_host.sv ----
`timescale 1ns/10ps
// Register bus master standing in for the programming host
module dcfg_host
(
    input  wire logic        clock,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    // Bus idle from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // One transfer, entered just after a rising edge
    task xfer(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        // Request held until ready is seen
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    // Offset bytes staged, low A byte last so the load takes them all
    task load_ofs(input logic [12:0] oa, input logic [12:0] ob);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, 12'h054, ob[7:0], r, e);
        xfer(1'b1, 12'h05c, {ob[12:8], 3'h0}, r, e);
        xfer(1'b1, 12'h058, {oa[12:8], 3'h0}, r, e);
        xfer(1'b1, 12'h050, oa[7:0], r, e);
    endtask
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
// Self-checking bench for the datapath configuration block
module tb_top;
    logic        clock = 1'b0;    // System clock
    logic        rst = 1'b1;      // Synchronous reset
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;           // Bus address
    logic [31:0] pwdata, prdata, r;
    logic        strobe = 1'b0;   // External sync strobe
    logic        frame = 1'b0;    // Frame marker
    logic        in_valid = 1'b0; // Sample strobe
    logic        out_valid, div_sync, autosync;
    logic [15:0] in_a = 16'h0, in_b = 16'h0, out_a, out_b, xa, xb, ya, yb;
    logic [1:0]  div_en;          // Divider enables
    logic [12:0] oa, ob;          // Offsets loaded
    logic [7:0]  pol, rt;         // Random control bytes
    int          mismatches = 0, tests_run = 0, seed = 51, n_as = 0, n_ds = 0, d0;

    // Free running clock
    always #5 clock = ~clock;

    // Pulse counters
    always @(posedge clock)
    begin
        n_as += (autosync === 1'b1);
        n_ds += (div_sync === 1'b1);
    end

    dcfg_top dcfg_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .external_sync_strobe(strobe), .frame_marker(frame), .in_valid(in_valid), .in_a(in_a),
        .in_b(in_b), .out_valid(out_valid), .out_a(out_a), .out_b(out_b), .div_sync(div_sync),
        .div_en(div_en), .autosync(autosync));

    dcfg_host dcfg_host_i (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // Value comparison
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task test_done;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Register shorthands
    task wr(input logic [11:0] a, input logic [7:0] d);
        dcfg_host_i.xfer(1'b1, a, d, r, e);
    endtask
    task rd(input logic [11:0] a);
        dcfg_host_i.xfer(1'b0, a, 8'h00, r, e);
    endtask

    // Word with bit order turned round
    function logic [15:0] rev16(input logic [15:0] x);
        for (int i = 0; i < 16; i++)
            rev16[i] = x[15 - i];
    endfunction
    // Complement then signed offset
    function logic [15:0] chan(input logic [15:0] x, input logic inv, input logic [12:0] o);
        chan = (inv ? ~x : x) + {{3{o[12]}}, o};
    endfunction

    // Hang guard
    initial
    begin
        #200000;
        mismatches++;
        test_done;
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Reset values
        for (int k = 0; k < 6; k++)
        begin
            rd(12'h048 + 12'(4 * k));
            chk(r, (k == 0) ? 32'h2 : 32'h0);
        end
        // Unmapped place reads zero with error
        rd(12'h064);
        chk({r[30:0], e}, 32'h1);
        // Staged bytes leave the active offset alone
        wr(12'h054, 8'h5a);
        wr(12'h058, 8'ha8);
        wr(12'h05c, 8'h38);
        rd(12'h060);
        chk(r, 32'h0);
        rd(12'h058);
        chk(r, 32'ha8);
        wr(12'h050, 8'h3c);
        rd(12'h060);
        chk(r, {5'h00, 5'h07, 8'h5a, 1'b0, 5'h15, 8'h3c});
        chk(n_as, 1);
        // Random routing, polarity, reversal and offsets
        in_valid <= 1'b1;
        for (int k = 0; k < 40; k++)
        begin
            pol = 8'($random(seed));
            rt = 8'($random(seed));
            if (rt[7])
                rt[6] = 1'b0;
            oa = 13'($random(seed));
            ob = 13'($random(seed));
            // Corners: inversion, each copy, reversal with zero offset, then offset alone
            if (k < 5)
            begin
                pol = (k == 0) ? 8'h0e : 8'h02;
                rt = (k == 1) ? 8'h80 : (k == 2) ? 8'h40 : (k == 3) ? 8'h01 : 8'h00;
                if (k < 4)
                begin
                    oa = 13'h0000;
                    ob = 13'h0000;
                end
            end
            wr(12'h048, pol);
            wr(12'h04c, rt);
            dcfg_host_i.load_ofs(oa, ob);
            rd(12'h04c);
            chk(r, {24'h0, rt});
            in_a <= 16'($random(seed));
            in_b <= 16'($random(seed));
            repeat (2) @(posedge clock);
            xa = rt[0] ? rev16(in_a) : in_a;
            xb = rt[0] ? rev16(in_b) : in_b;
            ya = rt[6] ? xb : xa;
            yb = rt[7] ? xa : xb;
            chk({out_a, out_b}, {chan(ya, pol[3], oa), chan(yb, pol[2], ob)});
            chk(out_valid, 32'h1);
        end
        // Divider sync from strobe, disabled, from frame, strobe ignored under frame
        for (int s = 0; s < 4; s++)
        begin
            wr(12'h048, (s == 1) ? 8'h00 : 8'h02);
            wr(12'h04c, (s >= 2) ? 8'h02 : 8'h00);
            d0 = n_ds;
            strobe <= (s != 2);
            frame <= (s == 2);
            repeat (4) @(posedge clock);
            chk(n_ds - d0, (s == 0 || s == 2) ? 1 : 0);
            // Phase zero one cycle after the event, so the fastest enable stands now
            if (s == 0 || s == 2)
                chk(div_en, 32'h1);
            strobe <= 1'b0;
            frame <= 1'b0;
            @(posedge clock);
        end
        test_done;
    end
endmodule
